// ==== bench/dcsc_render_model.sv ====
// behavioural renderer standing behind the draw handshake of the bank
// assumes the bank pulses draw_start and holds draw_busy while a shape runs
`timescale 1ns/100ps
module dcsc_render_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // engine control from the bank, delay from the bench
  input  wire logic       draw_start,
  input  wire logic       draw_busy,
  input  wire logic [7:0] delay,
  // completion back to the bank
  output      logic       draw_done
);
  logic [7:0] left;

  // counts delay cycles per shape, then pulses done once
  always_ff @(posedge clk) begin
    draw_done <= 1'b0;
    if (!reset_n) begin
      left <= 8'h00;
    end else if (draw_start) begin
      left <= delay;
    end else if (!draw_busy) begin
      left <= 8'h00;
    end else if (left != 8'h00) begin
      left      <= left - 8'h01;
      draw_done <= (left == 8'h01);
    end
  end
endmodule // dcsc_render_model

// ==== bench/tb_top.sv ====
// self-checking bench of the draw cursor and shape bank over APB
// assumes the bank answers each access on its own pready, renderer modelled aside
`timescale 1ns/100ps
`include "dcsc_defs.svh"
module tb_top;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mem_wr_step;
  logic        mem_rd_step;
  logic        draw_done;
  logic        draw_start;
  logic        draw_busy;
  logic [3:0]  draw_shape;
  logic        draw_fill;
  logic        draw_closed;
  logic        linear_mode;
  logic [1:0]  color_depth;
  logic [15:0] cur_wr_x, cur_wr_y, cur_rd_x, cur_rd_y;
  logic [15:0] text_x, text_y, point1_x, point1_y;
  logic [7:0]  delay;
  logic [31:0] rdat;
  logic        rerr;
  logic [3:0]  code;
  logic [7:0]  dv;
  logic        ok;
  int          fail_count = 0;
  int          checked = 0;
  int          starts = 0;
  int          s0;
  logic [7:0]  hi_idx [6] = '{`DCSC_IDX_GCUR_X_HI, `DCSC_IDX_GCUR_Y_HI, `DCSC_IDX_TCUR_X_HI,
                              `DCSC_IDX_TCUR_Y_HI, `DCSC_IDX_P1_X_HI, `DCSC_IDX_P1_Y_HI};

  dcsc_top #(.ADDR_W(10)) u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_wr_step(mem_wr_step), .mem_rd_step(mem_rd_step),
    .draw_done(draw_done), .draw_start(draw_start), .draw_busy(draw_busy),
    .draw_shape(draw_shape), .draw_fill(draw_fill), .draw_closed(draw_closed),
    .linear_mode(linear_mode), .color_depth(color_depth), .cur_wr_x(cur_wr_x),
    .cur_wr_y(cur_wr_y), .cur_rd_x(cur_rd_x), .cur_rd_y(cur_rd_y), .text_x(text_x),
    .text_y(text_y), .point1_x(point1_x), .point1_y(point1_y)
  );

  dcsc_render_model u_model (
    .clk(clk), .reset_n(reset_n), .draw_start(draw_start), .draw_busy(draw_busy),
    .delay(delay), .draw_done(draw_done)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (draw_start === 1'b1) starts <= starts + 1;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; pready and prdata are taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] strb);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'h1);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00, 4'h0);
    check(what, {24'h000000, exp}, rdat);
    check("pslverr", 32'h0, {31'h0, rerr});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic step(input logic rd);
    @(posedge clk);
    mem_rd_step <= rd;
    mem_wr_step <= !rd;
    @(posedge clk);
    mem_rd_step <= 1'b0;
    mem_wr_step <= 1'b0;
    #1;
  endtask

  initial begin
    #500000;
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    give_verdict();
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 10'h000;
    pwdata = 32'h0; pstrb = 4'h0; mem_wr_step = 1'b0; mem_rd_step = 1'b0; delay = 8'h1e;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 'h5e; i <= 'h6b; i++) rdchk(8'(i), 8'h00, "reset value");
    apb(1'b1, `DCSC_IDX_TCUR_X_LO, 8'hff, 4'h0);
    rdchk(`DCSC_IDX_TCUR_X_LO, 8'h00, "strobe off write");
    for (int i = 0; i < 6; i++) begin
      wr(hi_idx[i] - 8'h01, 8'hff);
      wr(hi_idx[i], 8'hff);
      rdchk(hi_idx[i], 8'h1f, "coord high byte");
      rdchk(hi_idx[i] - 8'h01, 8'hff, "coord low byte");
    end
    check("graphic cursor", 32'h1fff1fff, {cur_wr_x, cur_wr_y});
    check("text cursor", 32'h1fff1fff, {text_x, text_y});
    check("point one", 32'h1fff1fff, {point1_x, point1_y});
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h6c : 8'h5d, 8'h00, 4'h0);
      check("unmapped err", 32'h1, {31'h0, rerr});
      check("unmapped data", 32'h0, rdat);
    end
    wr(`DCSC_IDX_MODE, 8'hf7);
    rdchk(`DCSC_IDX_MODE, 8'h07, "mode reg");
    check("mode outputs", 32'h7, {29'h0, linear_mode, color_depth});
    wr(`DCSC_IDX_GCUR_X_LO, 8'hff);
    wr(`DCSC_IDX_GCUR_X_HI, 8'hff);
    wr(`DCSC_IDX_GCUR_Y_LO, 8'h01);
    wr(`DCSC_IDX_GCUR_Y_HI, 8'h00);
    rdchk(`DCSC_IDX_GCUR_X_HI, 8'hff, "linear x high");
    step(1'b0);
    check("linear step", 32'h00020000, {cur_wr_y, cur_wr_x});
    rdchk(`DCSC_IDX_GCUR_X_LO, 8'h00, "write pos readback");
    wr(`DCSC_IDX_MODE, 8'h0f);
    rdchk(`DCSC_IDX_GCUR_X_LO, 8'hff, "prefetch x readback");
    rdchk(`DCSC_IDX_GCUR_Y_LO, 8'h01, "prefetch y readback");
    step(1'b1);
    check("prefetch step", 32'h00020000, {cur_rd_y, cur_rd_x});
    rdchk(`DCSC_IDX_GCUR_Y_LO, 8'h02, "prefetch y stepped");
    wr(`DCSC_IDX_MODE, 8'h00);
    check("block mode", 32'h0, {31'h0, linear_mode});
    wr(`DCSC_IDX_GCUR_X_LO, 8'hff);
    wr(`DCSC_IDX_GCUR_X_HI, 8'hff);
    rdchk(`DCSC_IDX_GCUR_X_HI, 8'h1f, "block x high");
    step(1'b0);
    check("block step", 32'h00020000, {cur_wr_y, cur_wr_x});
    // every shape code, bit 6 written high to see it read back low
    s0 = starts;
    for (int c = 0; c < 16; c++) begin
      code = 4'(c);
      dv = {1'b1, 1'b1, code[0], code, code[1]};
      ok = !(code inside {4'h1, 4'ha, 4'hb});
      wr(`DCSC_IDX_DRAW, dv);
      tick(1);
      check("busy after start", {31'h0, ok}, {31'h0, draw_busy});
      check("draw fields", {26'h0, code, dv[5], dv[0]},
            {26'h0, draw_shape, draw_fill, draw_closed});
      rdchk(`DCSC_IDX_DRAW, {ok, 1'b0, dv[5:0]}, "draw ctl busy");
      for (int n = 0; n < 100 && draw_busy !== 1'b0; n++) tick(1);
      rdchk(`DCSC_IDX_DRAW, {2'b00, dv[5:0]}, "draw ctl done");
    end
    check("start pulses", 32'(s0 + 13), 32'(starts));
    delay = 8'hc8;
    s0 = starts;
    wr(`DCSC_IDX_DRAW, 8'h80);
    tick(3);
    wr(`DCSC_IDX_DRAW, 8'h80);
    tick(1);
    check("restart pulses", 32'(s0 + 2), 32'(starts));
    check("busy on restart", 32'h1, {31'h0, draw_busy});
    wr(`DCSC_IDX_DRAW, 8'h00);
    tick(1);
    check("busy after stop", 32'h0, {31'h0, draw_busy});
    rdchk(`DCSC_IDX_DRAW, 8'h00, "draw ctl stopped");
    give_verdict();
  end
endmodule // tb_top

// ==== hdl/dcsc_coord_reg.sv ====
// one 16-bit position held as a low and a high byte register
// assumes the caller gives byte write strobes and a whole-word load
`timescale 1ns/100ps
`include "dcsc_defs.svh"
module dcsc_coord_reg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // byte writes
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wr_data,
  input  wire logic [7:0]  hi_mask,
  // whole-word load from the memory stepper
  input  wire logic        ld,
  input  wire logic [15:0] ld_val,
  // held position
  output      logic [15:0] value
);
  dcsc_pkg::dcsc_coord_st_t st;
  dcsc_pkg::dcsc_coord_st_t next_st;

  // a host byte write overrides a concurrent step on that byte
  always_comb begin
    next_st = st;
    if (ld) begin
      next_st.val = ld_val;
    end
    if (wr_lo) begin
      next_st.val[7:0] = wr_data;
    end
    if (wr_hi) begin
      next_st.val[15:8] = wr_data & hi_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st.val <= `DCSC_RESET_WORD;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.val;

  chk_hi_masked: assert property (@(posedge clk) disable iff (!reset_n)
    wr_hi |=> (value[15:8] & ~$past(hi_mask)) == `DCSC_RESET_BYTE)
    else $error("masked high bits were stored");
endmodule // dcsc_coord_reg

// ==== hdl/dcsc_defs.svh ====
// register indices, field positions and reset values of the draw cursor and shape bank
// assumes the includer maps index n to APB byte address 4*n
//
// Overview of operation
// - graphic cursor X: low 5Fh, high 60h
// - cursor readback picks write or prefetch position
// - linear mode: X pair is address bits 15..0
// - linear mode: Y pair is address bits 31..16
// - block mode: X pair is 13-bit pixel X
// - block mode: Y pair is 13-bit pixel Y
// - graphic cursor Y: low 61h, high 62h
// - text cursor X: low 63h, high 64h
// - text cursor Y: low 65h, high 66h
// - bit 7 write starts/stops, reads busy
// - bit 5 fill; bit 6 reads zero
// - bits 4..1 select the shape
// - bit 0 closes the polyline
// - point 1 X: low 68h, high 69h
// - 5Eh bit 2: block or linear addressing
// - 5Eh bit 3: readback write or prefetch
// - point 1 Y: low 6Ah, high 6Bh
`ifndef DCSC_DEFS_SVH
`define DCSC_DEFS_SVH

`define DCSC_IDX_MODE       8'h5e
`define DCSC_IDX_GCUR_X_LO  8'h5f
`define DCSC_IDX_GCUR_X_HI  8'h60
`define DCSC_IDX_GCUR_Y_LO  8'h61
`define DCSC_IDX_GCUR_Y_HI  8'h62
`define DCSC_IDX_TCUR_X_LO  8'h63
`define DCSC_IDX_TCUR_X_HI  8'h64
`define DCSC_IDX_TCUR_Y_LO  8'h65
`define DCSC_IDX_TCUR_Y_HI  8'h66
`define DCSC_IDX_DRAW       8'h67
`define DCSC_IDX_P1_X_LO    8'h68
`define DCSC_IDX_P1_X_HI    8'h69
`define DCSC_IDX_P1_Y_LO    8'h6a
`define DCSC_IDX_P1_Y_HI    8'h6b

`define DCSC_MODE_RDSEL     3
`define DCSC_MODE_LINEAR    2
`define DCSC_MODE_DEPTH_HI  1
`define DCSC_MODE_DEPTH_LO  0
`define DCSC_DRAW_GO        7
`define DCSC_DRAW_FILL      5
`define DCSC_DRAW_SHAPE_HI  4
`define DCSC_DRAW_SHAPE_LO  1
`define DCSC_DRAW_CLOSED    0

`define DCSC_HI_MASK_COORD  8'h1f
`define DCSC_HI_MASK_LIN    8'hff
`define DCSC_COORD_W        13
`define DCSC_RESET_BYTE     8'h00
`define DCSC_RESET_WORD     16'h0000
`define DCSC_ADDR_MIN_W     10

`endif

// ==== hdl/dcsc_draw_ctl.sv ====
// busy sequencer for the line and shape engine
// assumes the renderer pulses done once per finished shape
`timescale 1ns/100ps
module dcsc_draw_ctl (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // requests
  input  wire logic start_req,
  input  wire logic stop_req,
  input  wire logic done,
  // status
  output      logic busy,
  output      logic start
);
  dcsc_pkg::dcsc_draw_st_t st;
  dcsc_pkg::dcsc_draw_st_t next_st;

  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    unique case (st.state)
      dcsc_pkg::DCSC_DRAW_IDLE: begin
        if (start_req) begin
          next_st.state = dcsc_pkg::DCSC_DRAW_RUN;
          next_st.start = 1'b1;
        end
      end
      dcsc_pkg::DCSC_DRAW_RUN: begin
        // a new start wins over a completion in the same cycle
        if (start_req) begin
          next_st.start = 1'b1;
        end else if (stop_req || done) begin
          next_st.state = dcsc_pkg::DCSC_DRAW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st.state <= dcsc_pkg::DCSC_DRAW_IDLE;
      st.start <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign busy  = (st.state == dcsc_pkg::DCSC_DRAW_RUN);
  assign start = st.start;

  chk_start_sets_busy: assert property (@(posedge clk) disable iff (!reset_n)
    start_req |=> busy && start)
    else $error("start did not raise busy");
  chk_stop_clears: assert property (@(posedge clk) disable iff (!reset_n)
    busy && stop_req && !start_req |=> !busy ##1 !busy || start)
    else $error("stop did not clear busy");
endmodule // dcsc_draw_ctl

// ==== hdl/dcsc_pkg.sv ====
// types shared by the draw cursor and shape bank
// assumes dcsc_defs.svh supplies all numeric constants
package dcsc_pkg;

  typedef enum logic [3:0] {
    DCSC_SHAPE_LINE    = 4'h0,
    DCSC_SHAPE_RECT    = 4'h2,
    DCSC_SHAPE_QUAD    = 4'h3,
    DCSC_SHAPE_PENT    = 4'h4,
    DCSC_SHAPE_POLY3   = 4'h5,
    DCSC_SHAPE_POLY4   = 4'h6,
    DCSC_SHAPE_POLY5   = 4'h7,
    DCSC_SHAPE_ELLIPSE = 4'h8,
    DCSC_SHAPE_RRECT   = 4'h9,
    DCSC_SHAPE_ARC_Q1  = 4'hc,
    DCSC_SHAPE_ARC_Q2  = 4'hd,
    DCSC_SHAPE_ARC_Q3  = 4'he,
    DCSC_SHAPE_ARC_Q4  = 4'hf
  } dcsc_shape_t;

  typedef enum logic {
    DCSC_DRAW_IDLE = 1'b0,
    DCSC_DRAW_RUN  = 1'b1
  } dcsc_draw_state_t;

  typedef struct packed {
    logic [15:0] val;
  } dcsc_coord_st_t;

  typedef struct packed {
    dcsc_draw_state_t state;
    logic             start;
  } dcsc_draw_st_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       ready;
    logic       slverr;
    logic       rdsel;
    logic       linear;
    logic [1:0] depth;
    logic       fill;
    logic [3:0] shape;
    logic       closed;
  } dcsc_top_st_t;

endpackage

// ==== hdl/dcsc_top.sv ====
// draw cursor and shape control register bank on an APB slave
// assumes APB3/4 master on clk; each byte register is one word at 4 * index
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "dcsc_defs.svh"
module dcsc_top #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  // memory datapath steps
  input  wire logic              mem_wr_step,
  input  wire logic              mem_rd_step,
  // renderer handshake
  input  wire logic              draw_done,
  output      logic              draw_start,
  output      logic              draw_busy,
  output      logic [3:0]        draw_shape,
  output      logic              draw_fill,
  output      logic              draw_closed,
  // positions and mode
  output      logic              linear_mode,
  output      logic [1:0]        color_depth,
  output      logic [15:0]       cur_wr_x,
  output      logic [15:0]       cur_wr_y,
  output      logic [15:0]       cur_rd_x,
  output      logic [15:0]       cur_rd_y,
  output      logic [15:0]       text_x,
  output      logic [15:0]       text_y,
  output      logic [15:0]       point1_x,
  output      logic [15:0]       point1_y
);
  if (ADDR_W < `DCSC_ADDR_MIN_W || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be 10..32");
  end

  dcsc_pkg::dcsc_top_st_t st;
  dcsc_pkg::dcsc_top_st_t next_st;

  logic [7:0]  word;
  logic        acc_wr;
  logic        hi_zero;
  logic [7:0]  wbyte;
  logic [7:0]  cur_mask;
  logic        wr_gx_lo;
  logic        wr_gx_hi;
  logic        wr_gy_lo;
  logic        wr_gy_hi;
  logic        wr_cur;
  logic        wr_mode;
  logic        wr_draw;
  logic        wr_tx_lo;
  logic        wr_tx_hi;
  logic        wr_ty_lo;
  logic        wr_ty_hi;
  logic        wr_p1x_lo;
  logic        wr_p1x_hi;
  logic        wr_p1y_lo;
  logic        wr_p1y_hi;
  logic [31:0] wr_lin_next;
  logic [31:0] rd_lin_next;
  logic [15:0] wr_x_next;
  logic [15:0] wr_y_next;
  logic [15:0] rd_x_next;
  logic [15:0] rd_y_next;
  logic        step_wr;
  logic        step_rd;
  logic        start_req;
  logic        stop_req;

  assign word    = paddr[9:2];
  assign hi_zero = (ADDR_W > `DCSC_ADDR_MIN_W) ? ~|(paddr >> `DCSC_ADDR_MIN_W) : 1'b1;
  assign acc_wr  = psel && penable && st.ready && pwrite && pstrb[0] && hi_zero;
  assign wbyte   = pwdata[7:0];

  function automatic logic shape_ok(input logic [3:0] code);
    shape_ok = !(code == 4'h1 || code == 4'ha || code == 4'hb);
  endfunction

  // linear mode keeps the whole high byte as address bits
  assign cur_mask = st.linear ? `DCSC_HI_MASK_LIN : `DCSC_HI_MASK_COORD;
  // strobes are plain nets so they follow acc_wr and word on every change
  assign wr_mode   = acc_wr && (word == `DCSC_IDX_MODE);
  assign wr_gx_lo  = acc_wr && (word == `DCSC_IDX_GCUR_X_LO);
  assign wr_gx_hi  = acc_wr && (word == `DCSC_IDX_GCUR_X_HI);
  assign wr_gy_lo  = acc_wr && (word == `DCSC_IDX_GCUR_Y_LO);
  assign wr_gy_hi  = acc_wr && (word == `DCSC_IDX_GCUR_Y_HI);
  assign wr_tx_lo  = acc_wr && (word == `DCSC_IDX_TCUR_X_LO);
  assign wr_tx_hi  = acc_wr && (word == `DCSC_IDX_TCUR_X_HI);
  assign wr_ty_lo  = acc_wr && (word == `DCSC_IDX_TCUR_Y_LO);
  assign wr_ty_hi  = acc_wr && (word == `DCSC_IDX_TCUR_Y_HI);
  assign wr_draw   = acc_wr && (word == `DCSC_IDX_DRAW);
  assign wr_p1x_lo = acc_wr && (word == `DCSC_IDX_P1_X_LO);
  assign wr_p1x_hi = acc_wr && (word == `DCSC_IDX_P1_X_HI);
  assign wr_p1y_lo = acc_wr && (word == `DCSC_IDX_P1_Y_LO);
  assign wr_p1y_hi = acc_wr && (word == `DCSC_IDX_P1_Y_HI);
  assign wr_cur   = wr_gx_lo || wr_gx_hi || wr_gy_lo || wr_gy_hi;

  // a cursor write sets both positions, so a datapath step in the same cycle is dropped
  assign step_wr = mem_wr_step && !wr_cur;
  assign step_rd = mem_rd_step && !wr_cur;

  // linear: Y:X is one byte address; block: X advances alone
  assign wr_lin_next = {cur_wr_y, cur_wr_x} + 32'h1;
  assign rd_lin_next = {cur_rd_y, cur_rd_x} + 32'h1;

  always_comb begin
    if (st.linear) begin
      wr_x_next = wr_lin_next[15:0];
      wr_y_next = wr_lin_next[31:16];
      rd_x_next = rd_lin_next[15:0];
      rd_y_next = rd_lin_next[31:16];
    end else begin
      wr_x_next = {3'h0, cur_wr_x[12:0] + 13'h1};
      wr_y_next = cur_wr_y;
      rd_x_next = {3'h0, cur_rd_x[12:0] + 13'h1};
      rd_y_next = cur_rd_y;
    end
  end

  // undefined shape codes never start the engine
  assign start_req = wr_draw && wbyte[`DCSC_DRAW_GO]
    && shape_ok(wbyte[`DCSC_DRAW_SHAPE_HI:`DCSC_DRAW_SHAPE_LO]);
  assign stop_req  = wr_draw && !wbyte[`DCSC_DRAW_GO];

  dcsc_coord_reg u_wr_x (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_gx_lo), .wr_hi(wr_gx_hi),
    .wr_data(wbyte), .hi_mask(cur_mask), .ld(step_wr), .ld_val(wr_x_next),
    .value(cur_wr_x));
  dcsc_coord_reg u_wr_y (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_gy_lo), .wr_hi(wr_gy_hi),
    .wr_data(wbyte), .hi_mask(cur_mask), .ld(step_wr), .ld_val(wr_y_next),
    .value(cur_wr_y));
  dcsc_coord_reg u_rd_x (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_gx_lo), .wr_hi(wr_gx_hi),
    .wr_data(wbyte), .hi_mask(cur_mask), .ld(step_rd), .ld_val(rd_x_next),
    .value(cur_rd_x));
  dcsc_coord_reg u_rd_y (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_gy_lo), .wr_hi(wr_gy_hi),
    .wr_data(wbyte), .hi_mask(cur_mask), .ld(step_rd), .ld_val(rd_y_next),
    .value(cur_rd_y));
  dcsc_coord_reg u_text_x (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_tx_lo),
    .wr_hi(wr_tx_hi), .wr_data(wbyte),
    .hi_mask(`DCSC_HI_MASK_COORD), .ld(1'b0), .ld_val(`DCSC_RESET_WORD),
    .value(text_x));
  dcsc_coord_reg u_text_y (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_ty_lo),
    .wr_hi(wr_ty_hi), .wr_data(wbyte),
    .hi_mask(`DCSC_HI_MASK_COORD), .ld(1'b0), .ld_val(`DCSC_RESET_WORD),
    .value(text_y));
  dcsc_coord_reg u_p1_x (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_p1x_lo),
    .wr_hi(wr_p1x_hi), .wr_data(wbyte),
    .hi_mask(`DCSC_HI_MASK_COORD), .ld(1'b0), .ld_val(`DCSC_RESET_WORD),
    .value(point1_x));
  dcsc_coord_reg u_p1_y (
    .clk(clk), .reset_n(reset_n), .wr_lo(wr_p1y_lo),
    .wr_hi(wr_p1y_hi), .wr_data(wbyte),
    .hi_mask(`DCSC_HI_MASK_COORD), .ld(1'b0), .ld_val(`DCSC_RESET_WORD),
    .value(point1_y));

  dcsc_draw_ctl u_draw (
    .clk(clk), .reset_n(reset_n), .start_req(start_req), .stop_req(stop_req),
    .done(draw_done), .busy(draw_busy), .start(draw_start));

  // access phase: one wait cycle, then pready; writes land with pready
  always_comb begin
    next_st        = st;
    next_st.ready  = 1'b0;
    next_st.slverr = 1'b0;
    if (psel && penable && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.rdata = `DCSC_RESET_BYTE;
      if (!hi_zero) begin
        next_st.slverr = 1'b1;
      end else begin
        unique case (word)
          `DCSC_IDX_MODE:
            next_st.rdata = {4'h0, st.rdsel, st.linear, st.depth};
          `DCSC_IDX_GCUR_X_LO:
            next_st.rdata = st.rdsel ? cur_rd_x[7:0] : cur_wr_x[7:0];
          `DCSC_IDX_GCUR_X_HI:
            next_st.rdata = st.rdsel ? cur_rd_x[15:8] : cur_wr_x[15:8];
          `DCSC_IDX_GCUR_Y_LO:
            next_st.rdata = st.rdsel ? cur_rd_y[7:0] : cur_wr_y[7:0];
          `DCSC_IDX_GCUR_Y_HI:
            next_st.rdata = st.rdsel ? cur_rd_y[15:8] : cur_wr_y[15:8];
          `DCSC_IDX_TCUR_X_LO: next_st.rdata = text_x[7:0];
          `DCSC_IDX_TCUR_X_HI: next_st.rdata = text_x[15:8];
          `DCSC_IDX_TCUR_Y_LO: next_st.rdata = text_y[7:0];
          `DCSC_IDX_TCUR_Y_HI: next_st.rdata = text_y[15:8];
          `DCSC_IDX_DRAW:
            next_st.rdata = {draw_busy, 1'b0, st.fill, st.shape, st.closed};
          `DCSC_IDX_P1_X_LO: next_st.rdata = point1_x[7:0];
          `DCSC_IDX_P1_X_HI: next_st.rdata = point1_x[15:8];
          `DCSC_IDX_P1_Y_LO: next_st.rdata = point1_y[7:0];
          `DCSC_IDX_P1_Y_HI: next_st.rdata = point1_y[15:8];
          default: next_st.slverr = 1'b1;
        endcase
      end
    end
    if (wr_mode) begin
      next_st.rdsel  = wbyte[`DCSC_MODE_RDSEL];
      next_st.linear = wbyte[`DCSC_MODE_LINEAR];
      next_st.depth  = wbyte[`DCSC_MODE_DEPTH_HI:`DCSC_MODE_DEPTH_LO];
    end
    if (wr_draw) begin
      next_st.fill   = wbyte[`DCSC_DRAW_FILL];
      next_st.shape  = wbyte[`DCSC_DRAW_SHAPE_HI:`DCSC_DRAW_SHAPE_LO];
      next_st.closed = wbyte[`DCSC_DRAW_CLOSED];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata      = {24'h000000, st.rdata};
  assign pready      = st.ready;
  assign pslverr     = st.slverr;
  assign linear_mode = st.linear;
  assign color_depth = st.depth;
  assign draw_shape  = st.shape;
  assign draw_fill   = st.fill;
  assign draw_closed = st.closed;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_curx_hi_mask: assert property (wr_gx_hi && !st.linear |=> cur_wr_x[15:13] == 3'h0)
    else $error("block cursor X kept unused bits");
  chk_cury_lin_full: assert property (wr_gy_hi && st.linear |=> cur_wr_y[15:8] == $past(wbyte))
    else $error("linear cursor Y high byte lost");
  chk_readback_sel: assert property (psel && penable && !pready && !pwrite
    && word == `DCSC_IDX_GCUR_X_LO && hi_zero
    |=> prdata[7:0] == ($past(st.rdsel) ? $past(cur_rd_x[7:0]) : $past(cur_wr_x[7:0])))
    else $error("cursor readback picked the wrong position");
  chk_lin_carry: assert property (st.linear && mem_wr_step && !wr_cur && cur_wr_x == 16'hffff
    |=> cur_wr_x == 16'h0000 && cur_wr_y == $past(cur_wr_y) + 16'h1)
    else $error("linear address did not carry into Y");
  chk_block_step: assert property (!st.linear && mem_rd_step && !wr_cur
    |=> cur_rd_y == $past(cur_rd_y) && cur_rd_x[15:13] == 3'h0)
    else $error("block step disturbed Y or high bits");
  chk_text_write: assert property (wr_tx_lo
    |=> text_x[7:0] == $past(wbyte) ##1 text_x[7:0] == $past(text_x[7:0]) || acc_wr)
    else $error("text X write not held");
  chk_go_busy: assert property (start_req |=> draw_busy ##1 draw_busy || $past(draw_done)
    || $past(stop_req))
    else $error("start did not hold busy");
  chk_bit6_zero: assert property (pready && word == `DCSC_IDX_DRAW |-> prdata[6] == 1'b0)
    else $error("draw control bit 6 read as one");
  chk_bad_shape: assert property (wr_draw && !draw_busy
    && !shape_ok(wbyte[`DCSC_DRAW_SHAPE_HI:`DCSC_DRAW_SHAPE_LO]) |=> !draw_start && !draw_busy)
    else $error("undefined shape started the engine");
  chk_done_clears: assert property (draw_busy && draw_done && !start_req |=> !draw_busy)
    else $error("completion left busy set");
  chk_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle after one wait");
  chk_cury_blk_mask: assert property (wr_gy_hi && !st.linear |=> cur_wr_y[15:13] == 3'h0)
    else $error("block cursor Y kept unused bits");
  chk_rd_lin_step: assert property (st.linear && mem_rd_step && !wr_cur
    |=> {cur_rd_y, cur_rd_x} == $past({cur_rd_y, cur_rd_x}) + 32'h1)
    else $error("linear prefetch address did not advance");
  chk_mode_fields: assert property (wr_mode |=> linear_mode == $past(wbyte[`DCSC_MODE_LINEAR])
    && st.rdsel == $past(wbyte[`DCSC_MODE_RDSEL]))
    else $error("mode bits not stored");
  chk_ty_lo_write: assert property (wr_ty_lo |=> text_y[7:0] == $past(wbyte))
    else $error("text Y low byte not stored");
  chk_texty_write: assert property (wr_ty_hi
    |=> text_y[15:8] == ($past(wbyte) & `DCSC_HI_MASK_COORD))
    else $error("text Y high byte not stored masked");
  chk_p1x_lo_write: assert property (wr_p1x_lo |=> point1_x[7:0] == $past(wbyte))
    else $error("point 1 X low byte not stored");
  chk_p1x_write: assert property (wr_p1x_hi
    |=> point1_x[15:8] == ($past(wbyte) & `DCSC_HI_MASK_COORD))
    else $error("point 1 X high byte not stored masked");
  chk_p1y_write: assert property (wr_p1y_lo |=> point1_y[7:0] == $past(wbyte))
    else $error("point 1 Y low byte not stored");
  chk_text_hi_zero: assert property (text_x[15:13] == 3'h0 && text_y[15:13] == 3'h0)
    else $error("text cursor unused bits set");
  chk_stop_idle: assert property (stop_req |=> !draw_busy)
    else $error("stop left the engine busy");
  chk_draw_fields: assert property (wr_draw |=> {draw_fill, draw_shape, draw_closed}
    == $past(wbyte[`DCSC_DRAW_FILL:`DCSC_DRAW_CLOSED]))
    else $error("draw control fields not stored");
endmodule // dcsc_top
